// ===== hdl/enc_input_pkg.sv
// Purpose: Shared constants and types of the encoder and revolution sensor input logic
// Assumes: One 100 MHz clock, synchronous active-high reset
// Notes: Position counts are signed two's complement
package enc_input_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  // Complementary activity needed on both pairs before choosing differential
  localparam int DETECT_TIME_NS = 2000;
  localparam int DETECT_CYCLES = DETECT_TIME_NS / CLK_PERIOD_NS;
  localparam int DET_W = 8;
  localparam logic [DET_W-1:0] DETECT_LAST = DET_W'(DETECT_CYCLES - 1);

  // ****************************************************************
  // Widths and reset values
  // ****************************************************************
  localparam int POS_W = 24;
  localparam int TURN_W = 16;
  localparam int PROD_W = POS_W + TURN_W + 2;
  localparam int ERR_W = PROD_W + 1;
  localparam logic [POS_W-1:0] POS_RESET = 24'h00_0000;
  localparam logic [DET_W-1:0] DET_RESET = 8'h00;

  // ****************************************************************
  // Modes
  // ****************************************************************
  typedef enum logic [1:0] {
    FOUR_CODES_PER_PERIOD = 2'b00,
    TWO_CODES_PER_PERIOD = 2'b01,
    ONE_CODE_PER_PERIOD = 2'b11
  } count_mode_type;

  typedef enum logic {
    ENC_SINGLE_ENDED = 1'b0,
    ENC_DIFFERENTIAL = 1'b1
  } enc_kind_type;

  // ****************************************************************
  // Carriers and state
  // ****************************************************************
  typedef struct packed {
    logic first_se;
    logic second_se;
    logic first_p;
    logic first_n;
    logic second_p;
    logic second_n;
    logic rev;
  } pin_bus_type;

  localparam logic [6:0] PINS_IDLE = 7'h7f;

  typedef struct packed {
    logic prev_first;
    logic prev_second;
    logic step_up;
    logic step_down;
    logic invalid;
  } dec_state_type;

  typedef struct packed {
    pin_bus_type sync1;
    pin_bus_type sync2;
    logic rev_active;
    logic rev_pulse;
    logic [DET_W-1:0] det_cnt;
    enc_kind_type kind;
    logic [POS_W-1:0] enc_pos;
    logic [POS_W-1:0] enc_base;
    logic [POS_W-1:0] step_base;
    logic mon_prev;
    logic slip;
    logic invalid;
  } main_state_type;

endpackage

// ===== hdl/encoder_and_rev_sensor_input.sv
// Purpose: Encoder decoding, type selection, revolution sensor and slip monitor
// Assumes: Pins are asynchronous and pulled high when open
// Notes: Position counts change four register stages after a pin edge
//
// Overview of operation
// [RQ1] Encoder gives two phase signals offset by a quarter period.
// [RQ2] Decoder supports one, two or four codes per signal period.
// [RQ3] Four codes per period is the working mode, counting every edge.
// [RQ4] Follows single-ended up to 200 kHz and differential up to 5 MHz.
// [RQ5] Accepts differential and single-ended encoders, path chosen by type.
// [RQ6] Count serves as position feedback or as a slip monitor.
// [RQ7] Auto-detect picks encoder type, otherwise the manual selection is used.
// [RQ8] Low revolution sensor level is active by default.
// [RQ9] Open revolution sensor input idles high, reading inactive.
// [RQ10] Inversion setting makes high revolution sensor level active.
// [RQ11] Sensor gives one or more active pulses per shaft turn.
// [RQ12] Monitor converts encoder counts to steps, flags slip over threshold.
// [RQ13] Direction from leading phase; simultaneous phase changes ignored.
`timescale 1ns/1ps
module encoder_and_rev_sensor_input
  import enc_input_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire pin_bus_type pins_i,
  input wire count_mode_type count_mode_i,
  input wire logic autodetect_en_i,
  input wire logic manual_diff_i,
  input wire logic rev_invert_i,
  input wire logic monitor_en_i,
  input wire logic [POS_W-1:0] step_pos_i,
  input wire logic [TURN_W-1:0] steps_per_turn_i,
  input wire logic [TURN_W-1:0] counts_per_turn_i,
  input wire logic [TURN_W-1:0] slip_threshold_i,
  input wire logic slip_clr_i,
  output logic [POS_W-1:0] enc_pos_o,
  output logic enc_diff_o,
  output logic invalid_o,
  output logic rev_active_o,
  output logic rev_pulse_o,
  output logic slip_o
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic signed [PROD_W-1:0] scale(input logic signed [POS_W:0] d,
                                                       input logic [TURN_W-1:0] k);
    logic signed [PROD_W-1:0] dw;
    logic signed [PROD_W-1:0] kw;
    // Operands widened first so the product keeps every bit
    dw = PROD_W'(d);
    kw = PROD_W'($signed({1'b0, k}));
    scale = dw * kw;
  endfunction

  main_state_type st_r;
  main_state_type st_nxt;
  logic sel_first;
  logic sel_second;
  logic dec_up;
  logic dec_down;
  logic dec_invalid;
  logic pairs_compl;
  logic signed [POS_W:0] enc_delta;
  logic signed [POS_W:0] step_delta;
  logic signed [ERR_W-1:0] mismatch;
  logic [ERR_W-1:0] mismatch_abs;
  logic [ERR_W-1:0] limit;
  logic slip_hit;
  logic rev_level_active;

  // ****************************************************************
  // Input path selection
  // ****************************************************************
  // [RQ5] channel source follows type
  assign sel_first = (st_r.kind == ENC_DIFFERENTIAL) ? st_r.sync2.first_p : st_r.sync2.first_se;
  assign sel_second = (st_r.kind == ENC_DIFFERENTIAL) ? st_r.sync2.second_p : st_r.sync2.second_se;
  assign pairs_compl = (st_r.sync2.first_p ^ st_r.sync2.first_n) && (st_r.sync2.second_p ^ st_r.sync2.second_n);

  // [RQ4] two-stage sync leaves margin at 5 MHz
  quad_decoder u_dec (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .quad_phase_first_i(sel_first),
    .quad_phase_second_i(sel_second),
    .count_mode_i(count_mode_i),
    .step_up_o(dec_up),
    .step_down_o(dec_down),
    .invalid_o(dec_invalid)
  );

  // ****************************************************************
  // Slip arithmetic
  // ****************************************************************
  // [RQ12] cross-multiplied to avoid division
  assign enc_delta = $signed({st_r.enc_pos[POS_W-1], st_r.enc_pos}) - $signed({st_r.enc_base[POS_W-1], st_r.enc_base});
  assign step_delta = $signed({step_pos_i[POS_W-1], step_pos_i}) - $signed({st_r.step_base[POS_W-1], st_r.step_base});
  assign mismatch = ERR_W'(scale(enc_delta, steps_per_turn_i)) - ERR_W'(scale(step_delta, counts_per_turn_i));
  assign mismatch_abs = mismatch[ERR_W-1] ? ERR_W'(-mismatch) : ERR_W'(mismatch);
  assign limit = ERR_W'(slip_threshold_i) * ERR_W'(counts_per_turn_i);
  assign slip_hit = st_r.mon_prev && (mismatch_abs > limit);

  // [RQ8] [RQ10] polarity choice
  assign rev_level_active = rev_invert_i ? st_r.sync2.rev : !st_r.sync2.rev;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = pins_i;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.invalid = dec_invalid;

    // [RQ7] auto-detect or manual type
    if (!autodetect_en_i) begin
      st_nxt.kind = manual_diff_i ? ENC_DIFFERENTIAL : ENC_SINGLE_ENDED;
      st_nxt.det_cnt = DET_RESET;
    end else if (!pairs_compl) begin
      st_nxt.kind = ENC_SINGLE_ENDED;
      st_nxt.det_cnt = DET_RESET;
    end else if (st_r.det_cnt == DETECT_LAST) begin
      st_nxt.kind = ENC_DIFFERENTIAL;
    end else begin
      st_nxt.det_cnt = st_r.det_cnt + 8'h01;
    end

    // [RQ13] count up or down
    if (dec_up) begin
      st_nxt.enc_pos = st_r.enc_pos + 24'h00_0001;
    end else if (dec_down) begin
      st_nxt.enc_pos = st_r.enc_pos - 24'h00_0001;
    end

    // [RQ9] idle-high input reads inactive
    st_nxt.rev_active = rev_level_active;
    // [RQ11] one pulse per activation
    st_nxt.rev_pulse = rev_level_active && !st_r.rev_active;

    // [RQ6] monitor use captures reference points
    st_nxt.mon_prev = monitor_en_i;
    if (monitor_en_i && !st_r.mon_prev) begin
      st_nxt.enc_base = st_r.enc_pos;
      st_nxt.step_base = step_pos_i;
    end
    // [RQ12] sticky slip, set beats clear
    if (monitor_en_i && slip_hit) begin
      st_nxt.slip = 1'b1;
    end else if (slip_clr_i) begin
      st_nxt.slip = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_r <= '{sync1: PINS_IDLE, sync2: PINS_IDLE, rev_active: 1'b0, rev_pulse: 1'b0, det_cnt: DET_RESET,
                kind: ENC_SINGLE_ENDED, enc_pos: POS_RESET, enc_base: POS_RESET, step_base: POS_RESET,
                mon_prev: 1'b0, slip: 1'b0, invalid: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign enc_pos_o = st_r.enc_pos;
  assign enc_diff_o = (st_r.kind == ENC_DIFFERENTIAL);
  assign invalid_o = st_r.invalid;
  assign rev_active_o = st_r.rev_active;
  assign rev_pulse_o = st_r.rev_pulse;
  assign slip_o = st_r.slip;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence compl_run_s;
    autodetect_en_i && pairs_compl;
  endsequence

  rev_default_a: assert property (!rev_invert_i && !st_r.sync2.rev |=> rev_active_o) // [RQ8]
    else $error("low sensor level not active by default");
  rev_invert_a: assert property (rev_invert_i && st_r.sync2.rev |=> rev_active_o) // [RQ10]
    else $error("inverted sensor high level not active");
  rev_idle_a: assert property (!rev_invert_i && st_r.sync2.rev |=> !rev_active_o) // [RQ9]
    else $error("idle-high sensor read as active");
  rev_edge_a: assert property (rev_pulse_o |-> rev_active_o && !$past(rev_active_o)) // [RQ11]
    else $error("sensor pulse without activation edge");
  pos_up_a: assert property (dec_up |=> enc_pos_o == $past(enc_pos_o) + 24'h00_0001) // [RQ13]
    else $error("up step did not increment position");
  pos_down_a: assert property (dec_down |=> enc_pos_o == $past(enc_pos_o) - 24'h00_0001) // [RQ13]
    else $error("down step did not decrement position");
  pos_hold_a: assert property (!dec_up && !dec_down |=> $stable(enc_pos_o)) // [RQ3]
    else $error("position moved without a step");
  type_manual_a: assert property (!autodetect_en_i |=> enc_diff_o == $past(manual_diff_i)) // [RQ7]
    else $error("manual encoder type not applied");
  type_auto_a: assert property (compl_run_s [*8] ##1 compl_run_s [*8] |-> ##[0:200] enc_diff_o) // [RQ7]
    else $error("differential encoder not detected");
  type_path_a: assert property (enc_diff_o |-> sel_first == st_r.sync2.first_p) // [RQ5]
    else $error("differential path not selected");
  slip_set_a: assert property (monitor_en_i && slip_hit |=> slip_o) // [RQ12]
    else $error("slip not flagged over threshold");
  slip_hold_a: assert property (slip_o && !slip_clr_i |=> slip_o) // [RQ12]
    else $error("slip flag dropped without clear");
  mon_base_a: assert property (monitor_en_i && !st_r.mon_prev |=> st_r.enc_base == $past(enc_pos_o)) // [RQ6]
    else $error("monitor reference not captured");

endmodule // encoder_and_rev_sensor_input

// ===== hdl/quad_decoder.sv
// Purpose: Quadrature edge decoder producing up, down and invalid pulses
// Assumes: Phase inputs already synchronised to ref_clk_i
// Notes: Pulses are registered, one cycle after the phase change is seen
`timescale 1ns/1ps
module quad_decoder
  import enc_input_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic quad_phase_first_i,
  input wire logic quad_phase_second_i,
  input wire count_mode_type count_mode_i,
  output logic step_up_o,
  output logic step_down_o,
  output logic invalid_o
);

  dec_state_type st_r;
  dec_state_type st_nxt;
  logic chg_first;
  logic chg_second;
  logic dir_up;

  assign chg_first = quad_phase_first_i ^ st_r.prev_first;
  assign chg_second = quad_phase_second_i ^ st_r.prev_second;
  // [RQ13] direction from phase lead
  assign dir_up = quad_phase_first_i ^ st_r.prev_second;

  always_comb begin
    st_nxt = st_r;
    st_nxt.prev_first = quad_phase_first_i;
    st_nxt.prev_second = quad_phase_second_i;
    st_nxt.step_up = 1'b0;
    st_nxt.step_down = 1'b0;
    st_nxt.invalid = 1'b0;
    // [RQ13] both phases moved together
    if (chg_first && chg_second) begin
      st_nxt.invalid = 1'b1;
    end else if (chg_first || chg_second) begin
      // [RQ2] code subdivision per period
      case (count_mode_i)
        // [RQ3] every edge of either phase
        FOUR_CODES_PER_PERIOD: begin
          st_nxt.step_up = dir_up;
          st_nxt.step_down = !dir_up;
        end
        TWO_CODES_PER_PERIOD: begin
          st_nxt.step_up = chg_first && dir_up;
          st_nxt.step_down = chg_first && !dir_up;
        end
        default: begin
          st_nxt.step_up = chg_first && !quad_phase_second_i && quad_phase_first_i;
          st_nxt.step_down = chg_first && !quad_phase_second_i && !quad_phase_first_i;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_r <= '{prev_first: 1'b1, prev_second: 1'b1, step_up: 1'b0, step_down: 1'b0, invalid: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign step_up_o = st_r.step_up;
  assign step_down_o = st_r.step_down;
  assign invalid_o = st_r.invalid;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence fwd_edge_s;
    (count_mode_i == FOUR_CODES_PER_PERIOD) && (chg_first ^ chg_second) && dir_up;
  endsequence

  sequence up_pulse_s;
    step_up_o && !step_down_o;
  endsequence

  four_code_up_a: assert property (fwd_edge_s |=> up_pulse_s) // [RQ3]
    else $error("edge in four-code mode gave no up count");
  invalid_quiet_a: assert property (invalid_o |-> !step_up_o && !step_down_o) // [RQ13]
    else $error("invalid transition produced a count");

endmodule // quad_decoder

// ===== tb/enc_partner.sv
// Purpose: Model of a quadrature encoder and a revolution sensor
// Assumes: Tasks are called just after a rising edge of ref_clk_i
// Notes: Lines not in use rest at the pulled-up level
`timescale 1ns/1ps
module enc_partner
  import enc_input_pkg::*;
(
  input wire logic ref_clk_i,
  output pin_bus_type pins_o
);
  // Starts at phase state 11 so it matches the idle synchroniser value
  logic [1:0] g_r = 2'h2;
  logic diff_r = 1'h0;
  logic rev_r = 1'h1;

  function automatic logic [1:0] ph(input logic [1:0] g);
    return (g == 2'h0) ? 2'h0 : (g == 2'h1) ? 2'h2 : (g == 2'h2) ? 2'h3 : 2'h1;
  endfunction

  always_comb begin
    pins_o = PINS_IDLE;
    pins_o.rev = rev_r;
    if (diff_r) begin
      {pins_o.first_p, pins_o.second_p} = ph(g_r);
      {pins_o.first_n, pins_o.second_n} = ~ph(g_r);
    end else begin
      {pins_o.first_se, pins_o.second_se} = ph(g_r);
    end
  end

  task automatic move(input int n, input logic up, input int gap);
    repeat (n) begin
      g_r <= up ? g_r + 2'h1 : g_r - 2'h1;
      repeat (gap) @(posedge ref_clk_i);
    end
  endtask

  // Both phases change together, a faulty encoder
  task automatic jump();
    g_r <= g_r + 2'h2;
    repeat (10) @(posedge ref_clk_i);
  endtask

  task automatic set_diff(input logic d);
    diff_r <= d;
  endtask

  task automatic set_rev(input logic v);
    rev_r <= v;
  endtask
endmodule // enc_partner

// ===== tb/tb_encoder_and_rev_sensor_input.sv
// Purpose: Self-checking bench of the encoder and revolution sensor input
// Assumes: 100 MHz clock, synchronous reset held 20 cycles
// Notes: Expected counts are tracked by the bench itself
`timescale 1ns/1ps
module tb_encoder_and_rev_sensor_input;
  import enc_input_pkg::*;
  logic ref_clk, rst, autodet, manual_diff, rev_inv, mon_en, slip_clr;
  count_mode_type count_mode;
  logic [POS_W-1:0] step_pos, enc_pos, exp_pos;
  logic [TURN_W-1:0] spt, cpt, thr;
  logic enc_diff, invalid, rev_active, rev_pulse, slip;
  pin_bus_type pins;
  int mismatches = 0;
  int check_count = 0;
  int inv_seen = 0;
  int rev_pulses = 0;

  enc_partner partner (.ref_clk_i(ref_clk), .pins_o(pins));
  encoder_and_rev_sensor_input dut (.ref_clk_i(ref_clk), .rst_i(rst), .pins_i(pins),
    .count_mode_i(count_mode), .autodetect_en_i(autodet), .manual_diff_i(manual_diff),
    .rev_invert_i(rev_inv), .monitor_en_i(mon_en), .step_pos_i(step_pos),
    .steps_per_turn_i(spt), .counts_per_turn_i(cpt), .slip_threshold_i(thr),
    .slip_clr_i(slip_clr), .enc_pos_o(enc_pos), .enc_diff_o(enc_diff), .invalid_o(invalid),
    .rev_active_o(rev_active), .rev_pulse_o(rev_pulse), .slip_o(slip));

  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (invalid === 1'h1) inv_seen++;
    if (rev_pulse === 1'h1) rev_pulses++;
  end

  // ****************************************
  // Compare and helper tasks
  // ****************************************
  task automatic check_pos(input logic [POS_W-1:0] got, input logic [POS_W-1:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp, input string what);
    check_pos(POS_W'(got), POS_W'(exp), what);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic run_edges(input int n, input logic up, input int gap, input int delta);
    partner.move(n, up, gap);
    exp_pos = up ? exp_pos + POS_W'(delta) : exp_pos - POS_W'(delta);
    wait_cyc(6);
    check_pos(enc_pos, exp_pos, "position");
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    check_pos(enc_pos, POS_RESET, "reset position");
    check_bit(enc_diff, 1'h0, "reset type");
    check_bit(rev_active, 1'h0, "open sensor");
    check_bit(slip, 1'h0, "reset slip");
  endtask

  task automatic t_modes();
    count_mode_type modes[2] = '{TWO_CODES_PER_PERIOD, ONE_CODE_PER_PERIOD};
    int per[2] = '{4, 2};
    run_edges(8, 1'h1, 125, 8);
    run_edges(4, 1'h0, 125, 4);
    for (int i = 0; i < 2; i++) begin
      count_mode <= modes[i];
      wait_cyc(2);
      run_edges(8, 1'h1, 20, per[i]);
      run_edges(8, 1'h0, 20, per[i]);
    end
    count_mode <= FOUR_CODES_PER_PERIOD;
    wait_cyc(2);
  endtask

  task automatic t_diff();
    manual_diff <= 1'h1;
    partner.set_diff(1'h1);
    wait_cyc(5);
    check_bit(enc_diff, 1'h1, "manual differential");
    run_edges(40, 1'h1, 5, 40);
  endtask

  task automatic t_auto();
    manual_diff <= 1'h0;
    wait_cyc(3);
    check_bit(enc_diff, 1'h0, "manual single");
    autodet <= 1'h1;
    wait_cyc(195);
    check_bit(enc_diff, 1'h0, "detect still counting");
    wait_cyc(10);
    check_bit(enc_diff, 1'h1, "detected differential");
    partner.set_diff(1'h0);
    wait_cyc(8);
    check_bit(enc_diff, 1'h0, "detected single");
    run_edges(4, 1'h1, 20, 4);
    autodet <= 1'h0;
  endtask

  task automatic t_invalid();
    inv_seen = 0;
    partner.jump();
    partner.jump();
    check_pos(POS_W'(inv_seen), POS_W'(2), "invalid pulses");
    check_pos(enc_pos, exp_pos, "no count on invalid");
  endtask

  task automatic t_rev();
    rev_pulses = 0;
    partner.set_rev(1'h0);
    wait_cyc(5);
    check_bit(rev_active, 1'h1, "low active");
    check_pos(POS_W'(rev_pulses), POS_W'(1), "activation pulse");
    partner.set_rev(1'h1);
    wait_cyc(5);
    check_bit(rev_active, 1'h0, "high inactive");
    rev_inv <= 1'h1;
    wait_cyc(5);
    check_bit(rev_active, 1'h1, "inverted high");
    partner.set_rev(1'h0);
    wait_cyc(5);
    check_bit(rev_active, 1'h0, "inverted low");
    rev_inv <= 1'h0;
    partner.set_rev(1'h1);
  endtask

  task automatic t_slip();
    mon_en <= 1'h1;
    wait_cyc(3);
    step_pos <= 24'h00_0003;
    wait_cyc(4);
    check_bit(slip, 1'h0, "at threshold");
    step_pos <= 24'h00_0004;
    wait_cyc(4);
    check_bit(slip, 1'h1, "over threshold");
    step_pos <= 24'h00_0000;
    wait_cyc(3);
    slip_clr <= 1'h1;
    wait_cyc(1);
    slip_clr <= 1'h0;
    mon_en <= 1'h0;
    step_pos <= 24'h00_0064;
    wait_cyc(4);
    check_bit(slip, 1'h0, "cleared, monitor off");
    mon_en <= 1'h1;
    wait_cyc(3);
    for (int i = 1; i <= 4; i++) begin
      run_edges(4, 1'h1, 5, 4);
      step_pos <= 24'h00_0064 + POS_W'(i);
    end
    wait_cyc(4);
    check_bit(slip, 1'h0, "encoder follows steps");
    // New scale and threshold, monitor re-armed at step 104
    mon_en <= 1'h0;
    spt <= 16'h0064;
    cpt <= 16'h0190;
    thr <= 16'h0001;
    wait_cyc(2);
    mon_en <= 1'h1;
    wait_cyc(3);
    step_pos <= 24'h00_0069;
    wait_cyc(4);
    check_bit(slip, 1'h0, "at new threshold");
    step_pos <= 24'h00_006a;
    wait_cyc(4);
    check_bit(slip, 1'h1, "over new threshold");
  endtask

  task automatic t_rerun();
    rst <= 1'h1;
    mon_en <= 1'h0;
    wait_cyc(3);
    rst <= 1'h0;
    exp_pos = POS_RESET;
    wait_cyc(3);
    t_reset();
    run_edges(4, 1'h0, 20, 4);
  endtask

  initial begin
    rst = 1'h1;
    count_mode = FOUR_CODES_PER_PERIOD;
    {autodet, manual_diff, rev_inv, mon_en, slip_clr} = 5'h00;
    step_pos = 24'h00_0000;
    spt = 16'h00c8;
    cpt = 16'h0320;
    thr = 16'h0003;
    exp_pos = POS_RESET;
    wait_cyc(20);
    rst <= 1'h0;
    wait_cyc(3);
    t_reset();
    t_modes();
    t_invalid();
    t_diff();
    t_auto();
    t_rev();
    t_slip();
    t_rerun();
    complete_run();
  end

  initial begin
    wait_cyc(50000);
    mismatches++;
    complete_run();
  end
endmodule // tb_encoder_and_rev_sensor_input
